// File: rtl/irqp_pkg.sv
package irqp_pkg;

  // Source count and split between debug and peripheral classes
  localparam int IRQP_NUM_SRC = 19;
  localparam int IRQP_NUM_DEBUG = 5;
  localparam int IRQP_SRC_W = 5;

  // Register word indices (byte address is four times the index)
  localparam logic [2:0] IRQP_IDX_BREAK_STEP = 3'h0;
  localparam logic [2:0] IRQP_IDX_DEBUG_CHAN = 3'h1;
  localparam logic [2:0] IRQP_IDX_SYSTEM = 3'h2;
  localparam logic [2:0] IRQP_IDX_PORT_CAN = 3'h3;
  localparam logic [2:0] IRQP_IDX_PENDING = 3'h4;

  // Reset value of every priority register
  localparam logic [15:0] IRQP_PRIO_RESET = 16'h0000;

  // Writable bits per register; all other bits are reserved
  localparam logic [15:0] IRQP_MASK_BREAK_STEP = 16'h3C00;
  localparam logic [15:0] IRQP_MASK_DEBUG_CHAN = 16'h003F;
  localparam logic [15:0] IRQP_MASK_SYSTEM = 16'hFFCF;
  localparam logic [15:0] IRQP_MASK_PORT_CAN = 16'hFFFC;

  // Field positions (low bit of each 2-bit field)
  localparam int IRQP_LSB_BREAKPOINT0 = 12;
  localparam int IRQP_LSB_STEP_COUNTER = 10;
  localparam int IRQP_LSB_DEBUG_RX_FULL = 4;
  localparam int IRQP_LSB_DEBUG_TX_EMPTY = 2;
  localparam int IRQP_LSB_TRACE_BUFFER = 0;
  localparam int IRQP_LSB_FLASH_EMPTY = 14;
  localparam int IRQP_LSB_FLASH_DONE = 12;
  localparam int IRQP_LSB_FLASH_ERROR = 10;
  localparam int IRQP_LSB_PLL_LOCK = 8;
  localparam int IRQP_LSB_LOW_VOLTAGE = 6;
  localparam int IRQP_LSB_EXT_B = 2;
  localparam int IRQP_LSB_EXT_A = 0;
  localparam int IRQP_LSB_PORT_D = 14;
  localparam int IRQP_LSB_PORT_E = 12;
  localparam int IRQP_LSB_PORT_F = 10;
  localparam int IRQP_LSB_CAN_MSG = 8;
  localparam int IRQP_LSB_CAN_WAKE = 6;
  localparam int IRQP_LSB_CAN_ERR = 4;
  localparam int IRQP_LSB_CAN_BUS_OFF = 2;

  // Field code that disables a source
  localparam logic [1:0] IRQP_FIELD_OFF = 2'h0;

  typedef enum logic [1:0] {
    IRQP_BUS_IDLE = 2'b01,
    IRQP_BUS_ANSWER = 2'b10
  } irqp_bus_state_t;

endpackage : irqp_pkg

// File: rtl/irqp_bus_if.sv
`timescale 1ns/1ps
`default_nettype none

interface irqp_bus_if;
  logic wr_en;
  logic hit;
  logic [2:0] index;
  logic [15:0] wdata;
  logic [1:0] lanes;
  logic [31:0] rdata;

  modport port (
    output wr_en, hit, index, wdata, lanes,
    input rdata
  );

  modport regs (
    input wr_en, hit, index, wdata, lanes,
    output rdata
  );
endinterface : irqp_bus_if

`default_nettype wire

// File: rtl/irqp_level_decode.sv
`timescale 1ns/1ps
`default_nettype none

module irqp_level_decode
  import irqp_pkg::*;
#(
  parameter bit IS_DEBUG = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Field and raw request
  input wire logic [1:0] field,
  input wire logic request,
  // Decoded outputs
  output logic enable,
  output logic [1:0] level,
  output logic pending
);

  wire field_on = (field != IRQP_FIELD_OFF);
  // Debug class counts 1..3, peripherals 0..2
  wire [1:0] next_level = IS_DEBUG ? field :
                          (field_on ? field - 2'h1 : 2'h0);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      enable <= 1'b0;
      level <= 2'h0;
      pending <= 1'b0;
    end else begin
      enable <= field_on;
      level <= next_level;
      pending <= request && field_on;
    end
  end

endmodule : irqp_level_decode

`default_nettype wire

// File: rtl/irqp_bus_port.sv
`timescale 1ns/1ps
`default_nettype none

module irqp_bus_port
  import irqp_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Register side
  irqp_bus_if.port bus
);

  irqp_bus_state_t state;
  wire [ADDR_W-1:0] word = avs_address >> 2;
  wire request = avs_read || avs_write;

  assign bus.hit = (avs_address[1:0] == 2'h0) &&
                   (word <= ADDR_W'(IRQP_IDX_PENDING));
  assign bus.index = word[2:0];
  assign bus.wdata = avs_writedata[15:0];
  assign bus.lanes = avs_byteenable[1:0];
  // Write lands on the edge where the master sees waitrequest low
  assign bus.wr_en = (state == IRQP_BUS_ANSWER) && avs_write;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= IRQP_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      case (state)
        IRQP_BUS_IDLE: begin
          if (request) begin
            state <= IRQP_BUS_ANSWER;
            avs_waitrequest <= 1'b0;
            avs_readdata <= (avs_read && bus.hit) ? bus.rdata : 32'h0;
          end
        end
        IRQP_BUS_ANSWER: begin
          state <= IRQP_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          state <= IRQP_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

endmodule : irqp_bus_port

`default_nettype wire

// File: rtl/irqp_priority_regs.sv
`timescale 1ns/1ps
`default_nettype none

module irqp_priority_regs
  import irqp_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Avalon-MM register slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Raw requests from the sources
  input wire logic [IRQP_NUM_SRC-1:0] src_request,
  // Decoded levels toward arbitration
  output logic [IRQP_NUM_SRC-1:0] src_enable,
  output logic [2*IRQP_NUM_SRC-1:0] src_level,
  output logic [IRQP_NUM_SRC-1:0] src_pending,
  // Winning request
  output logic top_valid,
  output logic [1:0] top_level,
  output logic [IRQP_SRC_W-1:0] top_source
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus port

  irqp_bus_if bus ();

  irqp_bus_port #(
    .ADDR_W(ADDR_W)
  ) u_bus_port (
    .sys_clk(sys_clk),
    .reset(reset),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .bus(bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Priority registers

  logic [15:0] debug_break_step_priority;
  logic [15:0] debug_channel_priority;
  logic [15:0] system_event_priority;
  logic [15:0] port_and_can_priority;

  ////////////////////////////////////////////////////////////////////////////
  // Write path

  // Byte lanes of the low half word
  wire [15:0] lane_mask = {{8{bus.lanes[1]}}, {8{bus.lanes[0]}}};

  // Register select, shared by the write and read paths
  wire sel_break_step = (bus.index == IRQP_IDX_BREAK_STEP);
  wire sel_debug_chan = (bus.index == IRQP_IDX_DEBUG_CHAN);
  wire sel_system = (bus.index == IRQP_IDX_SYSTEM);
  wire sel_port_can = (bus.index == IRQP_IDX_PORT_CAN);
  wire sel_pending = (bus.index == IRQP_IDX_PENDING);

  // Only aligned words inside the map are written
  wire write_hit = bus.wr_en && bus.hit;
  wire write_break_step = write_hit && sel_break_step;
  wire write_debug_chan = write_hit && sel_debug_chan;
  wire write_system = write_hit && sel_system;
  wire write_port_can = write_hit && sel_port_can;

  wire [15:0] keep_break_step = lane_mask & IRQP_MASK_BREAK_STEP;
  wire [15:0] keep_debug_chan = lane_mask & IRQP_MASK_DEBUG_CHAN;
  wire [15:0] keep_system = lane_mask & IRQP_MASK_SYSTEM;
  wire [15:0] keep_port_can = lane_mask & IRQP_MASK_PORT_CAN;

  // Bits outside the enabled lanes keep their old value
  wire [15:0] merged_break_step =
      (debug_break_step_priority & ~keep_break_step) |
      (bus.wdata & keep_break_step);
  wire [15:0] merged_debug_chan =
      (debug_channel_priority & ~keep_debug_chan) |
      (bus.wdata & keep_debug_chan);
  wire [15:0] merged_system =
      (system_event_priority & ~keep_system) |
      (bus.wdata & keep_system);
  wire [15:0] merged_port_can =
      (port_and_can_priority & ~keep_port_can) |
      (bus.wdata & keep_port_can);

  wire [15:0] next_debug_break_step_priority = write_break_step ?
      merged_break_step : debug_break_step_priority;
  wire [15:0] next_debug_channel_priority = write_debug_chan ?
      merged_debug_chan : debug_channel_priority;
  wire [15:0] next_system_event_priority = write_system ?
      merged_system : system_event_priority;
  wire [15:0] next_port_and_can_priority = write_port_can ?
      merged_port_can : port_and_can_priority;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  // One short process per register keeps each write path separate
  // Cleared on reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      debug_break_step_priority <= IRQP_PRIO_RESET;
    end else begin
      debug_break_step_priority <= next_debug_break_step_priority;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      debug_channel_priority <= IRQP_PRIO_RESET;
    end else begin
      debug_channel_priority <= next_debug_channel_priority;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      system_event_priority <= IRQP_PRIO_RESET;
    end else begin
      system_event_priority <= next_system_event_priority;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      port_and_can_priority <= IRQP_PRIO_RESET;
    end else begin
      port_and_can_priority <= next_port_and_can_priority;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction

  wire [1:0] breakpoint0_level =
      debug_break_step_priority[IRQP_LSB_BREAKPOINT0 +: 2];
  wire [1:0] step_counter_level =
      debug_break_step_priority[IRQP_LSB_STEP_COUNTER +: 2];

  wire [1:0] debug_rx_full_level =
      debug_channel_priority[IRQP_LSB_DEBUG_RX_FULL +: 2];
  wire [1:0] debug_tx_empty_level =
      debug_channel_priority[IRQP_LSB_DEBUG_TX_EMPTY +: 2];
  wire [1:0] trace_buffer_level =
      debug_channel_priority[IRQP_LSB_TRACE_BUFFER +: 2];

  wire [1:0] flash_buffers_empty_level =
      system_event_priority[IRQP_LSB_FLASH_EMPTY +: 2];
  wire [1:0] flash_command_done_level =
      system_event_priority[IRQP_LSB_FLASH_DONE +: 2];
  wire [1:0] flash_error_level =
      system_event_priority[IRQP_LSB_FLASH_ERROR +: 2];
  wire [1:0] pll_lock_loss_level =
      system_event_priority[IRQP_LSB_PLL_LOCK +: 2];
  wire [1:0] low_voltage_level =
      system_event_priority[IRQP_LSB_LOW_VOLTAGE +: 2];
  wire [1:0] ext_request_b_level =
      system_event_priority[IRQP_LSB_EXT_B +: 2];
  wire [1:0] ext_request_a_level =
      system_event_priority[IRQP_LSB_EXT_A +: 2];

  wire [1:0] port_d_level = port_and_can_priority[IRQP_LSB_PORT_D +: 2];
  wire [1:0] port_e_level = port_and_can_priority[IRQP_LSB_PORT_E +: 2];
  wire [1:0] port_f_level = port_and_can_priority[IRQP_LSB_PORT_F +: 2];
  wire [1:0] can_message_buffer_level =
      port_and_can_priority[IRQP_LSB_CAN_MSG +: 2];
  wire [1:0] can_wakeup_level =
      port_and_can_priority[IRQP_LSB_CAN_WAKE +: 2];
  wire [1:0] can_error_level =
      port_and_can_priority[IRQP_LSB_CAN_ERR +: 2];

  wire [1:0] can_bus_off_level =
      port_and_can_priority[IRQP_LSB_CAN_BUS_OFF +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Source numbering

  // Numbers seen on top_source and in the pending word;
  // debug class first, so the decode class follows the index
  localparam int SRC_BREAKPOINT0 = 0;
  localparam int SRC_STEP_COUNTER = 1;
  localparam int SRC_DEBUG_RX_FULL = 2;
  localparam int SRC_DEBUG_TX_EMPTY = 3;
  localparam int SRC_TRACE_BUFFER = 4;
  localparam int SRC_FLASH_EMPTY = 5;
  localparam int SRC_FLASH_DONE = 6;
  localparam int SRC_FLASH_ERROR = 7;
  localparam int SRC_PLL_LOCK = 8;
  localparam int SRC_LOW_VOLTAGE = 9;
  localparam int SRC_EXT_B = 10;
  localparam int SRC_EXT_A = 11;
  localparam int SRC_PORT_D = 12;
  localparam int SRC_PORT_E = 13;
  localparam int SRC_PORT_F = 14;
  localparam int SRC_CAN_MSG = 15;
  localparam int SRC_CAN_WAKE = 16;
  localparam int SRC_CAN_ERR = 17;
  localparam int SRC_CAN_BUS_OFF = 18;

  wire [2*IRQP_NUM_SRC-1:0] field_vec;

  // Debug class
  assign field_vec[2*SRC_BREAKPOINT0 +: 2] = breakpoint0_level;
  assign field_vec[2*SRC_STEP_COUNTER +: 2] = step_counter_level;
  assign field_vec[2*SRC_DEBUG_RX_FULL +: 2] = debug_rx_full_level;
  assign field_vec[2*SRC_DEBUG_TX_EMPTY +: 2] = debug_tx_empty_level;
  assign field_vec[2*SRC_TRACE_BUFFER +: 2] = trace_buffer_level;
  // System events
  assign field_vec[2*SRC_FLASH_EMPTY +: 2] = flash_buffers_empty_level;
  assign field_vec[2*SRC_FLASH_DONE +: 2] = flash_command_done_level;
  assign field_vec[2*SRC_FLASH_ERROR +: 2] = flash_error_level;
  assign field_vec[2*SRC_PLL_LOCK +: 2] = pll_lock_loss_level;
  assign field_vec[2*SRC_LOW_VOLTAGE +: 2] = low_voltage_level;
  assign field_vec[2*SRC_EXT_B +: 2] = ext_request_b_level;
  assign field_vec[2*SRC_EXT_A +: 2] = ext_request_a_level;
  // Ports and CAN
  assign field_vec[2*SRC_PORT_D +: 2] = port_d_level;
  assign field_vec[2*SRC_PORT_E +: 2] = port_e_level;
  assign field_vec[2*SRC_PORT_F +: 2] = port_f_level;
  assign field_vec[2*SRC_CAN_MSG +: 2] = can_message_buffer_level;
  assign field_vec[2*SRC_CAN_WAKE +: 2] = can_wakeup_level;
  assign field_vec[2*SRC_CAN_ERR +: 2] = can_error_level;
  assign field_vec[2*SRC_CAN_BUS_OFF +: 2] = can_bus_off_level;

  ////////////////////////////////////////////////////////////////////////////
  // Per-source decode

  genvar gi;
  generate
    for (gi = 0; gi < IRQP_NUM_SRC; gi = gi + 1) begin : g_src
      irqp_level_decode #(
        .IS_DEBUG(gi < IRQP_NUM_DEBUG)
      ) u_decode (
        .sys_clk(sys_clk),
        .reset(reset),
        .field(field_vec[2*gi +: 2]),
        .request(src_request[gi]),
        .enable(src_enable[gi]),
        .level(src_level[2*gi +: 2]),
        .pending(src_pending[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read back

  wire [15:0] read_break_step =
      debug_break_step_priority & IRQP_MASK_BREAK_STEP;
  wire [15:0] read_debug_chan =
      debug_channel_priority & IRQP_MASK_DEBUG_CHAN;
  wire [15:0] read_system = system_event_priority & IRQP_MASK_SYSTEM;
  wire [15:0] read_port_can = port_and_can_priority & IRQP_MASK_PORT_CAN;

  // Pending view lags the raw inputs by one cycle
  wire [31:0] read_pending = {{(32 - IRQP_NUM_SRC){1'b0}}, src_pending};

  assign bus.rdata =
      sel_break_step ? {16'h0000, read_break_step} :
      sel_debug_chan ? {16'h0000, read_debug_chan} :
      sel_system ? {16'h0000, read_system} :
      sel_port_can ? {16'h0000, read_port_can} :
      sel_pending ? read_pending :
      32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration

  // Highest level wins; on a tie the lower source number wins
  logic next_top_valid;
  logic [1:0] next_top_level;
  logic [IRQP_SRC_W-1:0] next_top_source;

  always_comb begin
    next_top_valid = 1'b0;
    next_top_level = 2'h0;
    next_top_source = '0;
    for (int i = 0; i < IRQP_NUM_SRC; i++) begin
      if (src_pending[i] &&
          (!next_top_valid || (src_level[2*i +: 2] > next_top_level)))
      begin
        next_top_valid = 1'b1;
        next_top_level = src_level[2*i +: 2];
        next_top_source = IRQP_SRC_W'(i);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      top_valid <= 1'b0;
      top_level <= 2'h0;
      top_source <= '0;
    end else begin
      top_valid <= next_top_valid;
      top_level <= next_top_level;
      top_source <= next_top_source;
    end
  end

endmodule : irqp_priority_regs

`default_nettype wire

// File: testbench/irqp_priority_regs_props.sv
`timescale 1ns/1ps
`default_nettype none

module irqp_priority_regs_props
  import irqp_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Sources and winner
  input wire logic [IRQP_NUM_SRC-1:0] src_request,
  input wire logic [IRQP_NUM_SRC-1:0] src_enable,
  input wire logic [2*IRQP_NUM_SRC-1:0] src_level,
  input wire logic [IRQP_NUM_SRC-1:0] src_pending,
  input wire logic top_valid,
  input wire logic [1:0] top_level,
  input wire logic [IRQP_SRC_W-1:0] top_source
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [IRQP_NUM_SRC-1:0] pend_q;
  logic [2*IRQP_NUM_SRC-1:0] lvl_q;
  logic dbg_bad, per_bad, hi_bad;
  logic [1:0] lv;
  // Writable bits per word; anything else must read zero
  wire logic [15:0] rd_mask = (avs_address == 5'h00) ? 16'h3C00 :
    (avs_address == 5'h04) ? 16'h003F :
    (avs_address == 5'h08) ? 16'hFFCF :
    (avs_address == 5'h0C) ? 16'hFFFC : 16'h0000;
  always_ff @(posedge sys_clk) begin
    pend_q <= src_pending;
    lvl_q <= src_level;
  end
  always_comb begin
    dbg_bad = 1'b0;
    per_bad = 1'b0;
    hi_bad = 1'b0;
    for (int i = 0; i < IRQP_NUM_SRC; i++) begin
      lv = src_level[2*i +: 2];
      if (i < IRQP_NUM_DEBUG) dbg_bad |= src_enable[i] == (lv == 2'h0);
      else per_bad |= (lv == 2'h3) || (!src_enable[i] && lv != 2'h0);
      hi_bad |= pend_q[i] && (lvl_q[2*i +: 2] > top_level);
    end
  end
  ////////////////////////////////////////
  // reset clears
  a_reset_clear: assert property (
    $past(reset) |-> src_enable == '0 && !top_valid && avs_waitrequest)
    else $error("outputs not clear after reset");
  a_debug_code: assert property (!dbg_bad)
    else $error("debug source level and enable disagree");
  a_periph_code: assert property (!per_bad)
    else $error("peripheral source level out of range");
  a_off_quiet: assert property (
    (src_pending & ~src_enable & ~$past(src_enable)) == '0)
    else $error("disabled source shows pending");
  a_top_any: assert property (top_valid == (|pend_q))
    else $error("top_valid does not follow pending");
  a_top_winner: assert property (
    top_valid |-> pend_q[top_source] && !hi_bad &&
    top_level == lvl_q[2*top_source +: 2])
    else $error("winner not the highest pending source");
  a_resv_zero: assert property (
    !avs_waitrequest && avs_read && avs_address < 5'h10 |->
    (avs_readdata & ~{16'h0000, rd_mask}) == 32'h0)
    else $error("reserved read bits not zero");
  a_answer_next: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
endmodule : irqp_priority_regs_props

bind irqp_priority_regs irqp_priority_regs_props #(.ADDR_W(ADDR_W)) u_props (
  .sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .src_request,
  .src_enable, .src_level, .src_pending, .top_valid, .top_level, .top_source
);

`default_nettype wire

// File: testbench/irqp_src_model.sv
`timescale 1ns/1ps
`default_nettype none

module irqp_src_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Requests wanted by the bench, raised as level requests
  input wire logic [18:0] want,
  output logic [18:0] src_request
);
  always_ff @(posedge sys_clk) begin
    if (reset) src_request <= '0;
    else src_request <= want;
  end
endmodule : irqp_src_model

`default_nettype wire

// File: testbench/irqp_priority_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module irqp_priority_regs_tb_top import irqp_pkg::*;;
  logic sys_clk, reset, avs_read, avs_write, avs_waitrequest, top_valid;
  logic [4:0] avs_address, top_source;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [18:0] want, src_request, src_enable, src_pending;
  logic [37:0] src_level;
  logic [1:0] top_level;
  int n_mismatch, comparisons, cycles;

  irqp_priority_regs u_irqp_priority_regs (.sys_clk, .reset, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .src_request, .src_enable, .src_level, .src_pending,
    .top_valid, .top_level, .top_source);
  irqp_src_model u_irqp_src_model (.sys_clk, .reset, .want, .src_request);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Run is about 150 cycles; the ceiling leaves wide margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task chk(input string w, input logic [37:0] e, input logic [37:0] g);
    comparisons++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", w, e, g);
      n_mismatch++;
    end
  endtask : chk

  task bus_wait();
    int n;
    n = 0;
    // Ends when waitrequest reads low; only the bench timeout bounds this wait
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    // Answer one edge after the take, seen on the next edge
    chk("wait_cycles", 38'd2, 38'(n));
  endtask : bus_wait

  task bus_wr(input logic [4:0] a, input logic [15:0] d,
      input logic [3:0] be = 4'h3);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
  endtask : bus_wr

  task bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  function automatic logic [1:0] xlv(int i, logic [1:0] f);
    if (f == 2'h0) return 2'h0;
    return (i < 5) ? f : f - 2'h1;
  endfunction : xlv
  ////////////////////////////////////////
  task t_reset();
    logic [31:0] d;
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("src_level", 38'h0, src_level);
    for (int r = 0; r < 4; r++) begin
      bus_rd(5'(4*r), d);
      chk("reg_reset", 38'h0, 38'(d));
    end
    $display("reset test done");
  endtask : t_reset

  task t_resv();
    logic [15:0] m [4];
    logic [31:0] d;
    m = '{16'h3C00, 16'h003F, 16'hFFCF, 16'hFFFC};
    for (int r = 0; r < 4; r++) begin
      bus_wr(5'(4*r), 16'hFFFF);
      bus_rd(5'(4*r), d);
      chk("reg_mask", 38'(m[r]), 38'(d));
    end
    bus_wr(5'h0C, 16'h0000);
    bus_wr(5'h0C, 16'hFFFF, 4'h1);
    bus_rd(5'h0C, d);
    chk("low_lane", 38'h00FC, 38'(d));
    $display("reserved test done");
  endtask : t_resv

  task t_unmap();
    logic [31:0] d;
    bus_wr(5'h14, 16'hFFFF);
    bus_rd(5'h14, d);
    chk("unmapped", 38'h0, 38'(d));
    bus_rd(5'h0C, d);
    chk("untouched", 38'h00FC, 38'(d));
    bus_rd(5'h0D, d);
    chk("unaligned", 38'h0, 38'(d));
    $display("unmapped test done");
  endtask : t_unmap

  task t_pending();
    logic [31:0] d;
    bus_wr(5'h00, 16'h0000);
    bus_wr(5'h04, 16'h0000);
    bus_wr(5'h08, 16'h0003);
    bus_wr(5'h0C, 16'h4000);
    // Source 18 stays disabled and must not win
    want <= 19'h41800;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("enable", 38'h01800, 38'(src_enable));
    chk("pending", 38'h01800, 38'(src_pending));
    chk("top_valid", 38'h1, 38'(top_valid));
    chk("top_source", 38'd11, 38'(top_source));
    chk("top_level", 38'h2, 38'(top_level));
    bus_rd(5'h10, d);
    chk("pend_reg", 38'h01800, 38'(d));
    want <= 19'h00000;
    $display("pending test done");
  endtask : t_pending

  task t_decode();
    logic [37:0] el;
    logic [18:0] ee;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) bus_wr(5'(4*r), {8{c[1:0]}});
      @(posedge sys_clk);
      #1;
      for (int i = 0; i < 19; i++) begin
        ee[i] = c != 0;
        el[2*i +: 2] = xlv(i, c[1:0]);
      end
      chk("enable", 38'(ee), 38'(src_enable));
      chk("src_level", el, src_level);
    end
    $display("decode test done");
  endtask : t_decode

  initial begin
    n_mismatch = 0;
    comparisons = 0;
    cycles = 0;
    reset = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h3;
    want = 19'h0;
    t_reset();
    t_resv();
    t_unmap();
    t_pending();
    t_decode();
    @(posedge sys_clk);
    t_reset();
    give_verdict();
  end
endmodule : irqp_priority_regs_tb_top

`default_nettype wire
